// [bench/jtag_tdr_checker_properties.sv]
// checker for the pin-control outputs of the test-port data registers
// assumes a bind to the top module; pin outputs lag the boundary value by one clock
`timescale 1ns/1ps
module jtag_tdr_checker (
	input wire logic         CLK_IN,
	input wire logic         RST_B_IN,
	input wire logic [2:0]   INSTRUCTION_OUT,
	input wire logic [195:0] BOUNDARY_VALUE_OUT,
	input wire logic         PINS_FROM_BOUNDARY_OUT,
	input wire logic         ALL_OUTPUTS_FLOAT_OUT,
	input wire logic         IRQ_PIN_OUT,
	input wire logic         IRQ_PIN_OE_OUT,
	input wire logic         TX_FRAME_START_OUT,
	input wire logic         TX_FRAME_START_OE_OUT
);
	default clocking dcb @(posedge CLK_IN);
	endclocking
	default disable iff (!RST_B_IN);
	a_irq_only_low: assert property (!IRQ_PIN_OUT)
		else $error("irq pin high");
	a_irq_drive_cond: assert property (IRQ_PIN_OE_OUT == (PINS_FROM_BOUNDARY_OUT &&
		!ALL_OUTPUTS_FLOAT_OUT && $past(BOUNDARY_VALUE_OUT[3:2]) == 2'h0)) else $error("irq enable wrong");
	a_fsof_dir: assert property (TX_FRAME_START_OE_OUT == (PINS_FROM_BOUNDARY_OUT &&
		!ALL_OUTPUTS_FLOAT_OUT && !$past(BOUNDARY_VALUE_OUT[24]))) else $error("frame start dir wrong");
	a_fsof_value: assert property (TX_FRAME_START_OUT == $past(BOUNDARY_VALUE_OUT[25]))
		else $error("frame start value wrong");
	a_highz_floats: assert property ((INSTRUCTION_OUT == 3'h4) [*2] |-> ALL_OUTPUTS_FLOAT_OUT)
		else $error("high-z not floating");
	a_cell0_float: assert property (PINS_FROM_BOUNDARY_OUT [*2] |->
		ALL_OUTPUTS_FLOAT_OUT == $past(BOUNDARY_VALUE_OUT[0])) else $error("float cell ignored");
	a_pins_mode: assert property ($stable(INSTRUCTION_OUT) |-> PINS_FROM_BOUNDARY_OUT ==
		(INSTRUCTION_OUT == 3'h0 || INSTRUCTION_OUT == 3'h3)) else $error("pin mode wrong");
	a_clamp_holds: assert property ((INSTRUCTION_OUT == 3'h3) [*2] |-> $stable(BOUNDARY_VALUE_OUT))
		else $error("clamp values moved");
endmodule
bind jtag_test_data_registers jtag_tdr_checker jtag_tdr_checker_inst (
	.CLK_IN(CLK_IN),
	.RST_B_IN(RST_B_IN),
	.INSTRUCTION_OUT(INSTRUCTION_OUT),
	.BOUNDARY_VALUE_OUT(BOUNDARY_VALUE_OUT),
	.PINS_FROM_BOUNDARY_OUT(PINS_FROM_BOUNDARY_OUT),
	.ALL_OUTPUTS_FLOAT_OUT(ALL_OUTPUTS_FLOAT_OUT),
	.IRQ_PIN_OUT(IRQ_PIN_OUT),
	.IRQ_PIN_OE_OUT(IRQ_PIN_OE_OUT),
	.TX_FRAME_START_OUT(TX_FRAME_START_OUT),
	.TX_FRAME_START_OE_OUT(TX_FRAME_START_OE_OUT)
);

// [bench/jtag_test_data_registers_tb.sv]
// self-checking bench for the test-port data registers
// assumes the tester model drives the test pins
`timescale 1ns/1ps
module jtag_test_data_registers_tb;
	logic         clk = 1'b0;
	logic         rst_b = 1'b0;
	logic [195:0] pins = {49{4'h6}};
	logic [195:0] o;
	wire          tck, tms, tdi, tdo, soe;
	logic         soe_seen = 1'b0;
	wire  [195:0] bv;
	wire  [22:0]  lsc, lsd;
	wire  [31:0]  idv;
	wire  [2:0]   ins;
	wire          pfb, flt, irq_oe, fs, fs_oe;
	integer       err_total = 0;
	integer       num_checks = 0;
	localparam [31:0] ID = {4'h1, 16'h1234, 11'h055, 1'b1};
	always #2.5 clk = ~clk;
	always @(negedge clk)
		if (soe)
			soe_seen <= 1'b1;
	jtag_test_data_registers jtag_test_data_registers_inst (
		.CLK_IN(clk), .RST_B_IN(rst_b), .TEST_CLOCK_PIN_IN(tck), .TEST_MODE_SELECT_PIN_IN(tms),
		.TEST_SERIAL_IN(tdi), .PIN_SAMPLE_IN(pins), .TEST_SERIAL_OUT(tdo), .TEST_SERIAL_OE_OUT(soe),
		.BOUNDARY_VALUE_OUT(bv), .PINS_FROM_BOUNDARY_OUT(pfb), .ALL_OUTPUTS_FLOAT_OUT(flt),
		.IRQ_PIN_OUT(), .IRQ_PIN_OE_OUT(irq_oe), .TX_FRAME_START_OUT(fs), .TX_FRAME_START_OE_OUT(fs_oe),
		.LS_RX_CLOCK_OUT(lsc), .LS_RX_DATA_OUT(lsd), .ID_VALUE_OUT(idv), .INSTRUCTION_OUT(ins));
	jtag_tester jtag_tester_inst (.clk_in(clk), .tdo_in(tdo), .tck_out(tck), .tms_out(tms), .tdi_out(tdi));
	task check(input logic [255:0] seen, input logic [255:0] exp);
	begin
		num_checks = num_checks + 1;
		if (seen !== exp)
		begin
			err_total = err_total + 1;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	end
	endtask
	task end_sim;
	begin
		$display("checks=%0d errors=%0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	end
	endtask
	task t_idcode;
	begin
		check(ins, 3'h1);
		jtag_tester_inst.dr(32, ID, o);
		check(o[31:0], ID);
		check(idv, ID);
		check({soe_seen, soe}, 2'h2);
		$display("idcode test done");
	end
	endtask
	task t_bypass(input logic [2:0] code);
	begin
		jtag_tester_inst.ir(code);
		check(ins, code);
		jtag_tester_inst.dr(8, 8'hb5, o);
		check(o[7:0], 8'h6a);
		check({flt, pfb}, {code == 3'h4, code == 3'h3});
		jtag_tester_inst.reset_tap;
		check(ins, 3'h1);
		$display("bypass test done");
	end
	endtask
	task t_boundary;
		logic [195:0] pre;
	begin
		pre = 196'h0;
		pre[25] = 1'b1;
		pre[38] = 1'b1;
		pre[127] = 1'b1;
		jtag_tester_inst.ir(3'h2);
		jtag_tester_inst.dr(196, pre, o);
		check(o, pins);
		check({bv, pfb, irq_oe}, {pre, 2'h0});
		jtag_tester_inst.ir(3'h0);
		check({pfb, flt, irq_oe, fs_oe, fs}, 5'h17);
		check({lsc[22], lsd[0], lsc[0], lsd[22]}, 4'hc);
		pre[0] = 1'b1;
		pre[24] = 1'b1;
		jtag_tester_inst.dr(196, pre, o);
		check(o, pins);
		check({flt, irq_oe, fs_oe, bv[0]}, 4'h9);
		jtag_tester_inst.ir(3'h3);
		check({pfb, flt, fs_oe, fs}, 4'hd);
		jtag_tester_inst.dr(8, 8'h0f, o);
		check(o[7:0], 8'h1e);
		check(bv, pre);
		$display("boundary test done");
	end
	endtask
	initial
	begin
		repeat (5) @(negedge clk);
		rst_b = 1'b1;
		repeat (4) @(negedge clk);
		jtag_tester_inst.reset_tap;
		t_idcode;
		t_bypass(3'h7);
		t_bypass(3'h3);
		t_bypass(3'h4);
		t_boundary;
		end_sim;
	end
	initial
	begin
		#200000;
		err_total = err_total + 1;
		end_sim;
	end
endmodule

// [bench/jtag_tester.sv]
// model of the external boundary-scan tester on the test pins
// assumes clk_in paces it; test clock idles low between frames
`timescale 1ns/1ps
module jtag_tester (
	input  wire logic clk_in,
	input  wire logic tdo_in,
	output logic      tck_out,
	output logic      tms_out,
	output logic      tdi_out
);
	initial
	begin
		tck_out = 1'b0;
		tms_out = 1'b1;
		tdi_out = 1'b0;
	end
	task pulse(input logic ms, input logic di, output logic so);
	begin
		@(negedge clk_in);
		tms_out = ms;
		tdi_out = di;
		repeat (11) @(negedge clk_in);
		tck_out = 1'b1;
		so = tdo_in;
		repeat (13) @(negedge clk_in);
		tck_out = 1'b0;
	end
	endtask
	task reset_tap;
		logic s;
	begin
		repeat (5) pulse(1'b1, 1'b0, s);
		pulse(1'b0, 1'b0, s);
	end
	endtask
	task ir(input logic [2:0] code);
		logic   s;
		integer i;
	begin
		pulse(1'b1, 1'b0, s);
		pulse(1'b1, 1'b0, s);
		pulse(1'b0, 1'b0, s);
		pulse(1'b0, 1'b0, s);
		for (i = 0; i < 3; i = i + 1)
			pulse(i == 2, code[i], s);
		pulse(1'b1, 1'b0, s);
		pulse(1'b0, 1'b0, s);
		tdi_out = ~tdi_out;
	end
	endtask
	task dr(input integer n, input logic [195:0] din, output logic [195:0] dout);
		logic   s;
		integer i;
	begin
		dout = 196'h0;
		pulse(1'b1, 1'b0, s);
		pulse(1'b0, 1'b0, s);
		pulse(1'b0, 1'b0, s);
		for (i = 0; i < n; i = i + 1)
		begin
			pulse(i == n - 1, din[i], s);
			dout[i] = s;
		end
		pulse(1'b1, 1'b0, s);
		pulse(1'b0, 1'b0, s);
		tdi_out = ~tdi_out;
	end
	endtask
endmodule

// [rtl/jtag_tdr_map.vh]
// constants for the test-port data registers: codes, widths, cell positions
// assumes inclusion by the data-register design file only; the scan cell bank does not include it
`ifndef JTAG_TDR_MAP_VH
`define JTAG_TDR_MAP_VH

`define IR_WIDTH           3
`define IR_EXTEST          3'h0
`define IR_IDCODE          3'h1
`define IR_SAMPLE          3'h2
`define IR_CLAMP           3'h3
`define IR_HIGHZ           3'h4
`define IR_BYPASS          3'h7
`define IR_CAPTURE_VALUE   3'h1

`define ID_WIDTH           32
`define ID_MFR_WIDTH       11
`define ID_PART_WIDTH      16
`define ID_VER_WIDTH       4

`define CHAIN_LEN          196
`define CELL_FLOAT         0
`define CELL_IRQ_DRIVE     2
`define CELL_IRQ_OUT       3
`define CELL_IRQ_IN        4
`define CELL_FSOF_DIR      24
`define CELL_FSOF_OUT      25
`define CELL_FSOF_IN       26
`define CELL_LS_BASE       36
`define CELL_LS_GROUP      4
`define CELL_LS_RXCLK      2
`define CELL_LS_RXDAT      3
`define LS_PORT_COUNT      23
`define LS_PORT_FIRST      6
`define LS_PORT_LAST       28

`endif

// [rtl/jtag_test_data_registers.v]
// test access port data registers: bypass, identification, boundary chain
// assumes the test pins come from an external tester, asynchronous to CLK_IN
`timescale 1ns/1ps
`include "jtag_tdr_map.vh"
module jtag_test_data_registers #(
	parameter [`ID_MFR_WIDTH-1:0]  ID_MFR  = 11'h0_55,  // arbitrary
	parameter [`ID_PART_WIDTH-1:0] ID_PART = 16'h1_234, // arbitrary
	parameter [`ID_VER_WIDTH-1:0]  ID_VER  = 4'h1       // arbitrary
) (
	input  wire                      CLK_IN,
	input  wire                      RST_B_IN,
	input  wire                      TEST_CLOCK_PIN_IN,
	input  wire                      TEST_MODE_SELECT_PIN_IN,
	input  wire                      TEST_SERIAL_IN,
	input  wire [`CHAIN_LEN-1:0]     PIN_SAMPLE_IN,
	output reg                       TEST_SERIAL_OUT,
	output reg                       TEST_SERIAL_OE_OUT,
	output wire [`CHAIN_LEN-1:0]     BOUNDARY_VALUE_OUT,
	output reg                       PINS_FROM_BOUNDARY_OUT,
	output reg                       ALL_OUTPUTS_FLOAT_OUT,
	output reg                       IRQ_PIN_OUT,
	output reg                       IRQ_PIN_OE_OUT,
	output reg                       TX_FRAME_START_OUT,
	output reg                       TX_FRAME_START_OE_OUT,
	output reg  [`LS_PORT_COUNT-1:0] LS_RX_CLOCK_OUT,
	output reg  [`LS_PORT_COUNT-1:0] LS_RX_DATA_OUT,
	output reg  [`ID_WIDTH-1:0]      ID_VALUE_OUT,
	output reg  [`IR_WIDTH-1:0]      INSTRUCTION_OUT
);
	localparam [3:0] ST_TLR   = 4'h0;
	localparam [3:0] ST_RTI   = 4'h1;
	localparam [3:0] ST_SELDR = 4'h2;
	localparam [3:0] ST_CAPDR = 4'h3;
	localparam [3:0] ST_SHDR  = 4'h4;
	localparam [3:0] ST_EX1DR = 4'h5;
	localparam [3:0] ST_PDR   = 4'h6;
	localparam [3:0] ST_EX2DR = 4'h7;
	localparam [3:0] ST_UPDR  = 4'h8;
	localparam [3:0] ST_SELIR = 4'h9;
	localparam [3:0] ST_CAPIR = 4'ha;
	localparam [3:0] ST_SHIR  = 4'hb;
	localparam [3:0] ST_EX1IR = 4'hc;
	localparam [3:0] ST_PIR   = 4'hd;
	localparam [3:0] ST_EX2IR = 4'he;
	localparam [3:0] ST_UPIR  = 4'hf;

	localparam [1:0] SEL_BYPASS = 2'h0;
	localparam [1:0] SEL_ID     = 2'h1;
	localparam [1:0] SEL_BSR    = 2'h2;

	// pin synchronisers
	reg                  tck_s1_ff;
	reg                  tck_s2_ff;
	reg                  tck_s3_ff;
	reg                  tms_s1_ff;
	reg                  tms_s2_ff;
	reg                  tdi_s1_ff;
	reg                  tdi_s2_ff;
	reg [`CHAIN_LEN-1:0] pin_s1_ff;
	reg [`CHAIN_LEN-1:0] pin_s2_ff;

	reg [3:0]            state_ff;
	reg [3:0]            nxt_state;
	reg [`IR_WIDTH-1:0]  ir_shift_ff;
	reg [`IR_WIDTH-1:0]  ir_par_ff;
	reg                  bypass_ff;
	reg [`ID_WIDTH-1:0]  id_shift_ff;

	wire tck_rise = tck_s2_ff & ~tck_s3_ff;
	wire tck_fall = ~tck_s2_ff & tck_s3_ff;
	wire [`ID_WIDTH-1:0] id_code = {ID_VER, ID_PART, ID_MFR, 1'b1};

	// instruction to register selection
	function [1:0] select_reg;
		input [`IR_WIDTH-1:0] ir;
		begin
			case (ir)
				`IR_EXTEST: select_reg = SEL_BSR;
				`IR_SAMPLE: select_reg = SEL_BSR;
				`IR_IDCODE: select_reg = SEL_ID;
				default:    select_reg = SEL_BYPASS;
			endcase
		end
	endfunction

	wire [1:0] sel      = select_reg(ir_par_ff);
	wire       dr_cap   = tck_rise & (state_ff == ST_CAPDR);
	wire       dr_shift = tck_rise & (state_ff == ST_SHDR);
	wire       dr_upd   = tck_fall & (state_ff == ST_UPDR);
	wire       bsr_sel  = (sel == SEL_BSR);
	wire       bsr_out;
	wire [`CHAIN_LEN-1:0] bsr_par;

	assign BOUNDARY_VALUE_OUT = bsr_par;

	always @(posedge CLK_IN or negedge RST_B_IN)
	begin
		if (!RST_B_IN)
		begin
			tck_s1_ff <= 1'b0;
			tck_s2_ff <= 1'b0;
			tck_s3_ff <= 1'b0;
			tms_s1_ff <= 1'b1;
			tms_s2_ff <= 1'b1;
			tdi_s1_ff <= 1'b1;
			tdi_s2_ff <= 1'b1;
			pin_s1_ff <= {`CHAIN_LEN{1'b0}};
			pin_s2_ff <= {`CHAIN_LEN{1'b0}};
		end
		else
		begin
			tck_s1_ff <= TEST_CLOCK_PIN_IN;
			tck_s2_ff <= tck_s1_ff;
			tck_s3_ff <= tck_s2_ff;
			tms_s1_ff <= TEST_MODE_SELECT_PIN_IN;
			tms_s2_ff <= tms_s1_ff;
			tdi_s1_ff <= TEST_SERIAL_IN;
			tdi_s2_ff <= tdi_s1_ff;
			pin_s1_ff <= PIN_SAMPLE_IN;
			pin_s2_ff <= pin_s1_ff;
		end
	end

	// test controller walk
	always @*
	begin
		case (state_ff)
			ST_TLR:   nxt_state = tms_s2_ff ? ST_TLR   : ST_RTI;
			ST_RTI:   nxt_state = tms_s2_ff ? ST_SELDR : ST_RTI;
			ST_SELDR: nxt_state = tms_s2_ff ? ST_SELIR : ST_CAPDR;
			ST_CAPDR: nxt_state = tms_s2_ff ? ST_EX1DR : ST_SHDR;
			ST_SHDR:  nxt_state = tms_s2_ff ? ST_EX1DR : ST_SHDR;
			ST_EX1DR: nxt_state = tms_s2_ff ? ST_UPDR  : ST_PDR;
			ST_PDR:   nxt_state = tms_s2_ff ? ST_EX2DR : ST_PDR;
			ST_EX2DR: nxt_state = tms_s2_ff ? ST_UPDR  : ST_SHDR;
			ST_UPDR:  nxt_state = tms_s2_ff ? ST_SELDR : ST_RTI;
			ST_SELIR: nxt_state = tms_s2_ff ? ST_TLR   : ST_CAPIR;
			ST_CAPIR: nxt_state = tms_s2_ff ? ST_EX1IR : ST_SHIR;
			ST_SHIR:  nxt_state = tms_s2_ff ? ST_EX1IR : ST_SHIR;
			ST_EX1IR: nxt_state = tms_s2_ff ? ST_UPIR  : ST_PIR;
			ST_PIR:   nxt_state = tms_s2_ff ? ST_EX2IR : ST_PIR;
			ST_EX2IR: nxt_state = tms_s2_ff ? ST_UPIR  : ST_SHIR;
			ST_UPIR:  nxt_state = tms_s2_ff ? ST_SELDR : ST_RTI;
			default:  nxt_state = ST_TLR;
		endcase
	end

	// controller, instruction, bypass and id stages
	always @(posedge CLK_IN or negedge RST_B_IN)
	begin
		if (!RST_B_IN)
		begin
			state_ff    <= ST_TLR;
			ir_shift_ff <= `IR_CAPTURE_VALUE;
			ir_par_ff   <= `IR_IDCODE;
			bypass_ff   <= 1'b0;
			id_shift_ff <= {`ID_WIDTH{1'b0}};
			ID_VALUE_OUT <= {`ID_WIDTH{1'b0}};
		end
		else
		begin
			if (tck_rise)
				state_ff <= nxt_state;
			if (state_ff == ST_TLR)
				ir_par_ff <= `IR_IDCODE;
			else if (tck_fall && state_ff == ST_UPIR)
				ir_par_ff <= ir_shift_ff;
			if (tck_rise && state_ff == ST_CAPIR)
				ir_shift_ff <= `IR_CAPTURE_VALUE;
			else if (tck_rise && state_ff == ST_SHIR)
				ir_shift_ff <= {tdi_s2_ff, ir_shift_ff[`IR_WIDTH-1:1]};
			if (sel == SEL_BYPASS && dr_cap)
				bypass_ff <= 1'b0;
			else if (sel == SEL_BYPASS && dr_shift)
				bypass_ff <= tdi_s2_ff;
			if (sel == SEL_ID && dr_cap)
				id_shift_ff <= id_code;
			else if (sel == SEL_ID && dr_shift)
				id_shift_ff <= {tdi_s2_ff, id_shift_ff[`ID_WIDTH-1:1]};
			if (sel == SEL_ID && dr_upd)
				ID_VALUE_OUT <= id_shift_ff;
		end
	end

	scan_cell_bank #(
		.WIDTH(`CHAIN_LEN)
	) u_boundary (
		.clk_in          (CLK_IN),
		.rst_b_in        (RST_B_IN),
		.capture_in      (dr_cap & bsr_sel),
		.shift_in        (dr_shift & bsr_sel),
		.update_in       (dr_upd & bsr_sel),
		.serial_in       (tdi_s2_ff),
		.capture_data_in (pin_s2_ff),
		.serial_out      (bsr_out),
		.parallel_out    (bsr_par)
	);

	// serial output changes on the falling test clock
	always @(posedge CLK_IN or negedge RST_B_IN)
	begin
		if (!RST_B_IN)
		begin
			TEST_SERIAL_OUT    <= 1'b0;
			TEST_SERIAL_OE_OUT <= 1'b0;
			INSTRUCTION_OUT    <= `IR_IDCODE;
		end
		else
		begin
			INSTRUCTION_OUT <= ir_par_ff;
			if (tck_fall)
			begin
				TEST_SERIAL_OE_OUT <= (state_ff == ST_SHDR) | (state_ff == ST_SHIR);
				if (state_ff == ST_SHIR)
					TEST_SERIAL_OUT <= ir_shift_ff[0];
				else if (sel == SEL_ID)
					TEST_SERIAL_OUT <= id_shift_ff[0];
				else if (sel == SEL_BSR)
					TEST_SERIAL_OUT <= bsr_out;
				else
					TEST_SERIAL_OUT <= bypass_ff;
			end
		end
	end

	// pin control from the boundary parallel stage
	wire bound_mode = (ir_par_ff == `IR_EXTEST) | (ir_par_ff == `IR_CLAMP);
	wire all_float  = (ir_par_ff == `IR_HIGHZ) | (bound_mode & bsr_par[`CELL_FLOAT]);

	always @(posedge CLK_IN or negedge RST_B_IN)
	begin
		if (!RST_B_IN)
		begin
			PINS_FROM_BOUNDARY_OUT <= 1'b0;
			ALL_OUTPUTS_FLOAT_OUT  <= 1'b0;
			IRQ_PIN_OUT            <= 1'b0;
			IRQ_PIN_OE_OUT         <= 1'b0;
			TX_FRAME_START_OUT     <= 1'b0;
			TX_FRAME_START_OE_OUT  <= 1'b0;
		end
		else
		begin
			PINS_FROM_BOUNDARY_OUT <= bound_mode;
			ALL_OUTPUTS_FLOAT_OUT  <= all_float;
			IRQ_PIN_OUT            <= 1'b0;
			IRQ_PIN_OE_OUT         <= bound_mode & ~all_float & ~bsr_par[`CELL_IRQ_DRIVE]
				& ~bsr_par[`CELL_IRQ_OUT];
			TX_FRAME_START_OUT     <= bsr_par[`CELL_FSOF_OUT];
			TX_FRAME_START_OE_OUT  <= bound_mode & ~all_float & ~bsr_par[`CELL_FSOF_DIR];
		end
	end

	// low-speed receive cells, group g serves port 28-g
	wire [`LS_PORT_COUNT-1:0] ls_clk_cells;
	wire [`LS_PORT_COUNT-1:0] ls_dat_cells;

	genvar g;
	generate
		for (g = 0; g < `LS_PORT_COUNT; g = g + 1)
		begin : g_ls
			assign ls_clk_cells[`LS_PORT_COUNT-1-g] =
				bsr_par[`CELL_LS_BASE + `CELL_LS_GROUP*g + `CELL_LS_RXCLK];
			assign ls_dat_cells[`LS_PORT_COUNT-1-g] =
				bsr_par[`CELL_LS_BASE + `CELL_LS_GROUP*g + `CELL_LS_RXDAT];
		end
	endgenerate

	always @(posedge CLK_IN or negedge RST_B_IN)
	begin
		if (!RST_B_IN)
		begin
			LS_RX_CLOCK_OUT <= {`LS_PORT_COUNT{1'b0}};
			LS_RX_DATA_OUT  <= {`LS_PORT_COUNT{1'b0}};
		end
		else
		begin
			LS_RX_CLOCK_OUT <= ls_clk_cells;
			LS_RX_DATA_OUT  <= ls_dat_cells;
		end
	end
endmodule

// [rtl/scan_cell_bank.v]
// shift stage plus latched parallel stage, one cell per bit
// assumes capture/shift/update strobes are one-cycle pulses on clk
`timescale 1ns/1ps
module scan_cell_bank #(
	parameter WIDTH = 196
) (
	input  wire             clk_in,
	input  wire             rst_b_in,
	input  wire             capture_in,
	input  wire             shift_in,
	input  wire             update_in,
	input  wire             serial_in,
	input  wire [WIDTH-1:0] capture_data_in,
	output wire             serial_out,
	output wire [WIDTH-1:0] parallel_out
);
	reg [WIDTH-1:0] shift_ff;
	reg [WIDTH-1:0] parallel_ff;

	assign serial_out   = shift_ff[0];
	assign parallel_out = parallel_ff;

	// parallel latch holds while new data shifts
	always @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			shift_ff    <= {WIDTH{1'b0}};
			parallel_ff <= {WIDTH{1'b0}};
		end
		else
		begin
			if (capture_in)
				shift_ff <= capture_data_in;
			else if (shift_in)
				shift_ff <= {serial_in, shift_ff[WIDTH-1:1]};
			if (update_in)
				parallel_ff <= shift_ff;
		end
	end
endmodule
